// ---- logic/itc_device.sv ----
// Device end: serial register slave, interrupt line control, temperature sequencer.
// Assumes link pins come from another clock domain; samples arrive on clk_in.
`timescale 1ns/1ps
module itc_device #(
  parameter logic [7:0] TEMP_OFFSET = itc_pkg::TEMP_OFFSET_DEF
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial link and interrupt line
  itc_link_if.dev link,
  // Converter inputs, digitised front-end levels
  input wire logic signed [itc_pkg::ADC_W-1:0] cur_sample_in,
  input wire logic signed [itc_pkg::ADC_W-1:0] volt_sample_in,
  input wire logic signed [itc_pkg::ADC_W-1:0] temp_sense_in,
  // Other interrupt sources, one-cycle pulses
  input wire logic [7:0] event_in,
  // Observed state
  output logic zx_out,
  output logic mod_bit_out,
  output logic signed [itc_pkg::ADC_W-1:0] adc_word_out,
  output logic [7:0] temp_out
);
  import itc_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    itc_dev_phase_t phase;
    logic [2:0] bitc;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic hold;
    logic [7:0] snap;
    logic [7:0] status;
    logic [7:0] mode;
    logic [7:0] irq_en;
    logic [7:0] temp;
    logic irq_lvl;
    logic irq_oe;
    logic miso;
    logic conv_busy;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic [1:0] mod_div;
    logic signed [INTEG_W-1:0] integ;
    logic mod_bit;
    logic signed [ADC_W-1:0] adc_word;
    logic signed [ADC_W-1:0] zx_filt;
    logic zx;
  } itc_dev_state_t;

  itc_dev_state_t r;
  itc_dev_state_t n;
  logic fall;
  logic rise;
  logic cs_act;
  logic zx_evt;
  logic tick;
  logic done;
  logic [7:0] rx_new;
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  logic signed [INTEG_W-1:0] mod_in;
  logic signed [INTEG_W-1:0] fb;

  // One step of a first-order low-pass toward a target
  function automatic logic signed [ADC_W-1:0] lpf_step(
    input logic signed [ADC_W-1:0] cur,
    input logic signed [ADC_W-1:0] tgt,
    input int sh
  );
    logic signed [ADC_W:0] diff;
    diff = {tgt[ADC_W-1], tgt} - {cur[ADC_W-1], cur};
    lpf_step = cur + ADC_W'(diff >>> sh);
  endfunction

  // Next-state logic
  always_comb begin
    n = r;
    done = 1'b0;
    clr_flags = '0;
    rx_new = '0;

    // Synchronisers on link pins
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.cs_s = {r.cs_s[0], link.cs_n};
    n.mosi_s = {r.mosi_s[0], link.mosi};
    fall = r.sclk_s[2] & ~r.sclk_s[1];
    rise = ~r.sclk_s[2] & r.sclk_s[1];
    cs_act = ~r.cs_s[1];

    // Zero crossing from the filtered voltage channel
    n.zx_filt = lpf_step(r.zx_filt, volt_sample_in, ZX_SHIFT);
    n.zx = ~r.zx_filt[ADC_W-1];
    zx_evt = n.zx ^ r.zx;

    // Modulator and averaging filter, ticked at a quarter of clk_in
    tick = (r.mod_div == MOD_DIV_LAST);
    n.mod_div = tick ? '0 : r.mod_div + 2'h1;
    mod_in = INTEG_W'(r.conv_busy ? temp_sense_in : cur_sample_in);
    fb = r.mod_bit ? INTEG_W'(MOD_FS) : -INTEG_W'(MOD_FS);
    if (tick) begin
      n.integ = r.integ + mod_in - fb;
      n.mod_bit = ~n.integ[INTEG_W-1];
      n.adc_word = lpf_step(r.adc_word, r.mod_bit ? MOD_FS : -MOD_FS, LPF_SHIFT);
    end

    // Temperature sequencer
    if (r.conv_busy) begin
      n.conv_cnt = r.conv_cnt + 5'h01;
      if (r.conv_cnt == CONV_LAST) begin
        n.conv_busy = 1'b0;
        n.temp = r.adc_word[ADC_W-1 -: BYTE_W] - TEMP_OFFSET;
        n.mode[TEMP_REQ_BIT] = 1'b0;
        done = 1'b1;
      end
    end else if (r.mode[TEMP_REQ_BIT] && zx_evt) begin
      n.conv_busy = 1'b1;
      n.conv_cnt = '0;
    end

    // Events always latch, whatever the enables
    set_flags = event_in;
    set_flags[TEMP_DONE_BIT] = event_in[TEMP_DONE_BIT] | done;

    // Events that arrive while a clearing read is open stay pending
    if (r.hold) begin
      n.snap = r.snap & ~set_flags;
    end

    // Serial slave: sample on falling sclk, shift out on rising sclk
    if (!cs_act) begin
      n.phase = DEV_CMD;
      n.bitc = '0;
      n.hold = 1'b0;
      n.miso = 1'b0;
    end else if (fall) begin
      rx_new = {r.rx[6:0], r.mosi_s[1]};
      n.rx = rx_new;
      n.bitc = r.bitc + 3'h1;
      if (r.bitc == BYTE_LAST) begin
        if (r.phase == DEV_CMD) begin
          n.phase = DEV_DATA;
          n.addr = rx_new[ADDR_W-1:0];
          n.rd = ~rx_new[CMD_WR_BIT];
          n.tx = '0;
          if (!rx_new[CMD_WR_BIT]) begin
            // Read decode
            if (rx_new[ADDR_W-1:0] == ADDR_STATUS) begin
              n.tx = r.status;
            end else if (rx_new[ADDR_W-1:0] == ADDR_STATUS_CLR) begin
              n.tx = r.status;
              n.snap = r.status;
              n.hold = 1'b1;
            end else if (rx_new[ADDR_W-1:0] == ADDR_MODE) begin
              n.tx = n.mode;
            end else if (rx_new[ADDR_W-1:0] == ADDR_IRQ_EN) begin
              n.tx = r.irq_en;
            end else if (rx_new[ADDR_W-1:0] == ADDR_TEMP) begin
              n.tx = r.temp;
            end
          end
        end else begin
          n.phase = DEV_CMD;
          n.miso = 1'b0;
          // Write decode, unmapped addresses ignored
          if (!r.rd) begin
            if (r.addr == ADDR_MODE) begin
              n.mode = rx_new;
            end else if (r.addr == ADDR_IRQ_EN) begin
              n.irq_en = rx_new;
            end
          end
          // Status byte fully shifted: clear what was returned
          if (r.hold) begin
            clr_flags = r.snap;
            n.hold = 1'b0;
          end
        end
      end
    end else if (rise && r.phase == DEV_DATA && r.rd) begin
      n.miso = r.tx[BYTE_W-1];
      n.tx = {r.tx[6:0], 1'b0};
    end

    // A new event wins over a clear in the same cycle
    n.status = (r.status & ~clr_flags) | set_flags;
    n.irq_lvl = 1'b0;
    n.irq_oe = ~n.hold & |(n.status & n.irq_en);
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.cs_s <= 2'h3;
      r.status <= STATUS_RST;
      r.mode <= MODE_RST;
      r.irq_en <= IRQ_EN_RST;
      r.temp <= TEMP_RST;
      r.zx <= ZX_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign link.miso = r.miso;
  assign link.irq_o = r.irq_lvl;
  assign link.irq_oe = r.irq_oe;
  assign zx_out = r.zx;
  assign mod_bit_out = r.mod_bit;
  assign adc_word_out = r.adc_word;
  assign temp_out = r.temp;

endmodule

// ---- logic/itc_host.sv ----
// Host end: serial master with interrupt service sequencer and a register port.
// Assumes irq and miso arrive asynchronously; sclk is made here by dividing clk_in.
`timescale 1ns/1ps
module itc_host (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Serial link and interrupt line
  itc_link_if.host link,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [itc_pkg::HREG_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [itc_pkg::HREG_W-1:0] reg_rdata_out,
  // Service routine report
  output logic [7:0] svc_status_out,
  output logic svc_valid_out
);
  import itc_pkg::*;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [1:0] miso_s;
    logic [2:0] irq_s;
    itc_host_phase_t phase;
    logic [DIV_W-1:0] div;
    logic [4:0] bitc;
    logic [XFER_BITS-1:0] sh;
    logic [7:0] shin;
    logic [7:0] result;
    logic gie;
    logic ext_flag;
    logic in_isr;
    logic pend;
    logic [XFER_BITS-1:0] cmd;
    logic [HREG_W-1:0] rdata;
    logic [7:0] svc_status;
    logic svc_valid;
  } itc_host_state_t;

  itc_host_state_t r;
  itc_host_state_t n;
  logic irq_fall;
  logic enter;
  logic launch;

  // Next-state logic
  always_comb begin
    n = r;
    n.svc_valid = 1'b0;
    n.rdata = '0;
    n.miso_s = {r.miso_s[0], link.miso};
    n.irq_s = {r.irq_s[1:0], link.irq_n};
    irq_fall = r.irq_s[2] & ~r.irq_s[1];

    // Register port reads, data valid the next cycle
    if (reg_rd_in) begin
      if (reg_addr_in == HREG_RESULT) begin
        n.rdata = HREG_W'({r.pend | (r.phase != HOST_IDLE), r.in_isr, r.result});
      end else if (reg_addr_in == HREG_CFG) begin
        n.rdata = HREG_W'(r.gie);
      end
    end
    // Register port writes; a command while one is queued is dropped
    if (reg_wr_in) begin
      if (reg_addr_in == HREG_CMD && !r.pend) begin
        n.pend = 1'b1;
        n.cmd = reg_wdata_in;
      end else if (reg_addr_in == HREG_CFG) begin
        n.gie = reg_wdata_in[CFG_GIE_BIT];
      end
    end

    // Service entry: mask, clear the flag, then the clearing read
    enter = (r.phase == HOST_IDLE) && !r.in_isr && r.gie && r.ext_flag;
    launch = (r.phase == HOST_IDLE) && !r.in_isr && !enter && r.pend;
    n.ext_flag = (r.ext_flag & ~enter) | irq_fall;
    if (enter || launch) begin
      n.phase = HOST_SHIFT;
      n.cs_n = 1'b0;
      n.sclk = 1'b0;
      n.div = '0;
      n.bitc = '0;
      n.sh = enter ? {2'h0, ADDR_STATUS_CLR, 8'h00} : r.cmd;
      n.in_isr = enter;
      if (launch) begin
        n.pend = 1'b0;
      end
    end

    // Serial master: data out on rising sclk, sample on falling
    case (r.phase)
      HOST_SHIFT: begin
        n.div = r.div + 8'h01;
        if (r.div == HALF_LAST) begin
          n.div = '0;
          if (!r.sclk) begin
            n.sclk = 1'b1;
            n.mosi = r.sh[XFER_BITS-1];
            n.sh = {r.sh[XFER_BITS-2:0], 1'b0};
          end else begin
            n.sclk = 1'b0;
            n.shin = {r.shin[6:0], r.miso_s[1]};
            n.bitc = r.bitc + 5'h01;
            if (r.bitc == XFER_LAST) begin
              n.phase = HOST_GAP;
            end
          end
        end
      end
      HOST_GAP: begin
        n.div = r.div + 8'h01;
        n.mosi = 1'b0;
        if (r.div == HALF_LAST) begin
          n.div = '0;
          if (!r.cs_n) begin
            n.cs_n = 1'b1;
          end else begin
            n.phase = HOST_IDLE;
            n.result = r.shin;
            if (r.in_isr) begin
              n.svc_status = r.shin;
              n.svc_valid = 1'b1;
              n.in_isr = 1'b0;
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.irq_s <= 3'h7;
      r.gie <= CFG_GIE_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
  assign reg_rdata_out = r.rdata;
  assign svc_status_out = r.svc_status;
  assign svc_valid_out = r.svc_valid;

endmodule

// ---- logic/itc_link_if.sv ----
// Serial link and open-drain interrupt line between device and host.
// Assumes an external pull-up on the interrupt wire, modelled here.
`timescale 1ns/1ps
interface itc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq_o;
  logic irq_oe;
  logic irq_n;

  // Wire level: pulled high unless the device drives it
  assign irq_n = irq_oe ? irq_o : 1'b1;

  modport dev (input sclk, input cs_n, input mosi, output miso, output irq_o, output irq_oe);
  modport host (output sclk, output cs_n, output mosi, input miso, input irq_n);
endinterface

// ---- logic/itc_pkg.sv ----
// Shared constants and types for the interrupt and temperature conversion link.
// Assumes one 200 MHz master clock at both ends and a four-wire serial link plus irq.
package itc_pkg;

  // Datapath widths
  localparam int ADC_W = 20;
  localparam int INTEG_W = 24;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 6;

  // Device register addresses (serial command byte, low bits)
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_STATUS_CLR = 6'h05;
  localparam logic [5:0] ADDR_MODE = 6'h06;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h0A;
  localparam logic [5:0] ADDR_TEMP = 6'h0B;
  localparam int CMD_WR_BIT = 7;

  // Field positions
  localparam int TEMP_REQ_BIT = 5;
  localparam int TEMP_DONE_BIT = 5;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] TEMP_OFFSET_DEF = 8'h00;
  localparam logic ZX_RST = 1'b1;

  // Timing counts in master clock cycles, then filter shifts, modulator full scale and last bit of a byte
  localparam int TEMP_CONV_CYCLES = 24;
  localparam int CONV_CNT_W = 5;
  localparam logic [4:0] CONV_LAST = 5'(TEMP_CONV_CYCLES - 1);
  localparam int MOD_DIV = 4;
  localparam logic [1:0] MOD_DIV_LAST = 2'(MOD_DIV - 1);
  localparam int LPF_SHIFT = 4;
  localparam int ZX_SHIFT = 6;
  localparam logic signed [19:0] MOD_FS = 20'sh40000;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Host serial timing
  localparam int SCLK_HALF = 12;
  localparam int DIV_W = 8;
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam int XFER_BITS = 16;
  localparam logic [4:0] XFER_LAST = 5'(XFER_BITS - 1);

  // Host register port
  localparam int HREG_W = 16;
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_RESULT = 4'h4;
  localparam logic [3:0] HREG_CFG = 4'h8;
  localparam int CFG_GIE_BIT = 0;
  localparam logic CFG_GIE_RST = 1'b1;

  // State enumerations
  typedef enum logic [1:0] {DEV_CMD, DEV_DATA} itc_dev_phase_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_SHIFT, HOST_GAP} itc_host_phase_t;

endpackage

// ---- verif/itc_link_asserts.sv ----
// Checker for the serial link and interrupt wire between host and device.
// Assumes it sits beside the link interface, on the master clock.
`timescale 1ns/1ps
module itc_link_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic irq_n
);
  logic sclk_q;
  logic fall;
  logic clr;
  logic [4:0] nfall;
  logic [7:0] sh;

  // A falling serial clock edge as seen on the master clock
  assign fall = sclk_q && !sclk;

  // Count falls in a frame and remember a clearing status read
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_q <= 1'b0;
      nfall <= 5'h00;
      sh <= 8'h00;
      clr <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        nfall <= 5'h00;
        clr <= 1'b0;
      end else if (fall) begin
        nfall <= nfall + 5'h01;
        sh <= {sh[6:0], mosi};
        if (nfall == 5'h07) begin
          clr <= ({sh[6:0], mosi} == 8'h05);
        end
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_irq_open_drain: assert property (irq_oe |-> !irq_o)
    else $error("interrupt wire driven high");
  a_irq_release_cmd: assert property (fall && nfall == 5'h07 && {sh[6:0], mosi} == 8'h05
    |-> ##[1:6] irq_n) else $error("interrupt not released after command byte");
  a_irq_hold_data: assert property (clr && nfall > 5'h08 && nfall < 5'h10 |-> irq_n)
    else $error("interrupt low during status byte");
  a_irq_rise_when: assert property ($rose(irq_n) && !cs_n |-> nfall == 5'h08)
    else $error("interrupt released at wrong bit");
  a_frame_len: assert property ($rose(cs_n) |-> nfall == 5'h10)
    else $error("frame not two whole bytes");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock runs while deselected");
  a_mosi_hold: assert property (fall |-> $stable(mosi))
    else $error("host data moved at sampling edge");
  a_miso_hold: assert property (fall |-> $stable(miso))
    else $error("device data moved at sampling edge");

  // Main scenarios
  c_clear_read: cover property (fall && nfall == 5'h07 && {sh[6:0], mosi} == 8'h05);
  c_irq_low: cover property ($fell(irq_n));
  c_frame_end: cover property ($rose(cs_n));
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench: host and device joined by the link interface.
// Assumes a 200 MHz master clock; both ends are design code, no models.
`timescale 1ns/1ps
module testbench;
  import itc_pkg::*;
  typedef struct {logic [15:0] cmd; logic [7:0] exp;} itc_row_t;
  logic clk_in;
  logic resetn_in;
  logic [3:0] reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [15:0] reg_rdata_out;
  logic [7:0] svc_status_out;
  logic svc_valid_out;
  logic signed [19:0] cur_in;
  logic signed [19:0] volt_in;
  logic signed [19:0] temp_in;
  logic [7:0] event_in;
  logic zx_out;
  logic [7:0] temp_out;
  logic mod_bit_out;
  logic signed [19:0] adc_out;
  logic mb;
  logic [15:0] rd;
  int failures;
  int cmp_count;
  int cycles;
  int n;
  itc_row_t rows [6];

  itc_link_if link ();
  itc_device itc_device_i (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .cur_sample_in(cur_in), .volt_sample_in(volt_in), .temp_sense_in(temp_in),
    .event_in(event_in), .zx_out(zx_out), .mod_bit_out(mod_bit_out), .adc_word_out(adc_out),
    .temp_out(temp_out));
  itc_host itc_host_i (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .svc_status_out(svc_status_out), .svc_valid_out(svc_valid_out));
  itc_link_asserts itc_link_asserts_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .irq_o(link.irq_o), .irq_oe(link.irq_oe), .irq_n(link.irq_n));

  task automatic close_out();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register port cycles, entered just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdreg(input logic [3:0] a);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    rd = reg_rdata_out;
    @(posedge clk_in);
  endtask

  // One device transfer through the host, then poll until idle
  task automatic dev(input logic [15:0] c);
    int k;
    wr(HREG_CMD, c);
    rd = 16'hFFFF;
    for (k = 0; k < 2000 && rd[9] !== 1'b0; k++) begin
      rdreg(HREG_RESULT);
    end
    chk8({7'h00, rd[9]}, 8'h00);
  endtask

  task automatic pulse(input logic [7:0] b);
    event_in <= b;
    @(posedge clk_in);
    event_in <= 8'h00;
    @(posedge clk_in);
  endtask

  task automatic wait_svc(input logic [7:0] e);
    int k;
    @(negedge clk_in);
    for (k = 0; k < 4000 && svc_valid_out !== 1'b1; k++) begin
      @(negedge clk_in);
    end
    chk8({7'h00, svc_valid_out}, 8'h01);
    chk8(svc_status_out, e);
    @(posedge clk_in);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles > 60000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    resetn_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    cur_in = 20'sh00000;
    volt_in = 20'sh10000;
    temp_in = 20'sh00000;
    event_in = 8'h00;
    rows[0] = '{16'h8AA5, 8'h00};
    rows[1] = '{16'h0A00, 8'hA5};
    rows[2] = '{16'h8A00, 8'h00};
    rows[3] = '{16'h0A00, 8'h00};
    rows[4] = '{16'h0400, 8'h00};
    rows[5] = '{16'h0600, 8'h00};
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk8({link.cs_n, link.sclk, link.irq_n, zx_out, svc_valid_out, 3'h0}, 8'hB0);
    chk8(temp_out, TEMP_RST);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rdreg(HREG_CFG);
    chk8(rd[7:0], {7'h00, CFG_GIE_RST});
    rdreg(4'hC);
    chk8(rd[7:0], 8'h00);
    $display("reset test done");
    for (n = 0; n < 6; n++) begin
      dev(rows[n].cmd);
      chk8(rd[7:0], rows[n].exp);
    end
    $display("register rows done");
    // Zero input: bit stream flips once per modulator tick, filter stays near zero
    @(negedge clk_in);
    mb = mod_bit_out;
    for (n = 0; n < 8 && mod_bit_out === mb; n++) @(negedge clk_in);
    mb = mod_bit_out;
    for (n = 0; n < 8 && mod_bit_out === mb; n++) @(negedge clk_in);
    chk8(8'(n), 8'(MOD_DIV));
    chk8({7'h00, adc_out > -20'sh04000 && adc_out < 20'sh04000}, 8'h01);
    @(posedge clk_in);
    $display("modulator test done");
    // Flag without enable: no interrupt, cleared by the clearing read
    pulse(8'h08);
    repeat (8) @(negedge clk_in);
    chk8({7'h00, link.irq_n}, 8'h01);
    @(posedge clk_in);
    dev(16'h0400);
    chk8(rd[7:0], 8'h08);
    dev(16'h0500);
    chk8(rd[7:0], 8'h08);
    dev(16'h0400);
    chk8(rd[7:0], 8'h00);
    $display("masked flag test done");
    // Service routine with a second event inside the status byte
    dev(16'h8A0C);
    pulse(8'h08);
    for (n = 0; n < 20 && link.irq_n !== 1'b0; n++) @(negedge clk_in);
    chk8({7'h00, link.irq_n}, 8'h00);
    for (n = 0; n < 1000 && link.irq_n !== 1'b1; n++) @(negedge clk_in);
    chk8({7'h00, link.irq_n}, 8'h01);
    repeat (20) @(posedge clk_in);
    pulse(8'h0C);
    wait_svc(8'h08);
    chk8({7'h00, link.irq_n}, 8'h00);
    wait_svc(8'h0C);
    chk8({7'h00, link.irq_n}, 8'h01);
    $display("service test done");
    // Temperature request waits for a zero crossing, done raises irq
    dev(16'h8A20);
    dev(16'h8620);
    volt_in <= -20'sh10000;
    for (n = 0; n < 2000 && zx_out !== 1'b0; n++) @(negedge clk_in);
    chk8({7'h00, zx_out}, 8'h00);
    for (n = 0; n < 60 && link.irq_n !== 1'b0; n++) @(negedge clk_in);
    chk8({7'h00, n >= 23 && n <= 28}, 8'h01);
    wait_svc(8'h20);
    chk8({7'h00, $signed(temp_out) > -8'sd8 && $signed(temp_out) < 8'sd8}, 8'h01);
    dev(16'h0B00);
    chk8({7'h00, $signed(rd[7:0]) > -8'sd8 && $signed(rd[7:0]) < 8'sd8}, 8'h01);
    dev(16'h0600);
    chk8(rd[7:0], 8'h00);
    $display("temperature test done");
    close_out();
  end
endmodule
